/* design/sram_host_ctrl.v */
// host controller driving an asynchronous 512K x 8 static memory
// Contract
// - every read and write cycle lasts at least cycle time.
// - select and write enable overlap at least write pulse width.
// - address stable from write start, held through write end.
// - chip select low long enough before write end.
// - write data valid setup time before write end, hold zero.
// - host never drives pins while device may still drive them.
// - write pulse with output enable low covers setup plus float.
// - deselect before retention; wait a cycle time after leaving.
`timescale 1ns/1ps
`include "sram_host_map.vh"

module sram_host_ctrl (
  // clock and reset
  input  wire                i_clk_sys,
  input  wire                i_arst_n,
  // user request
  input  wire                i_req,
  input  wire                i_req_write,
  input  wire [`ADDR_W-1:0]  i_req_addr,
  input  wire [`DATA_W-1:0]  i_req_wdata,
  input  wire                i_retain,
  output reg                 o_ready,
  output reg                 o_rvalid,
  output reg  [`DATA_W-1:0]  o_rdata,
  // memory pins
  output reg  [`ADDR_W-1:0]  o_word_address,
  output reg                 o_cs_n,
  output reg                 o_oe_n,
  output reg                 o_we_n,
  input  wire [`DATA_W-1:0]  i_data_pins,
  output reg  [`DATA_W-1:0]  o_data_pins,
  output reg                 o_data_pins_oe
);

  // ========================================================================
  // states
  localparam [6:0] ST_IDLE   = 7'h01;
  localparam [6:0] ST_RD     = 7'h02;
  localparam [6:0] ST_WR     = 7'h04;
  localparam [6:0] ST_WR_END = 7'h08;
  localparam [6:0] ST_GAP    = 7'h10;
  localparam [6:0] ST_RETAIN = 7'h20;
  localparam [6:0] ST_WAKE   = 7'h40;

  // ========================================================================
  // cycle counts; one extra cycle on reads covers the two-flop sampling
  localparam [31:0] RD_FULL   = `CEIL_CYC(`T_ACCESS_NS) + 1;
  localparam [31:0] WP_SETUP  = `CEIL_CYC(`T_DATA_SETUP_NS + `T_FLOAT_NS);
  localparam [31:0] WP_ADDR   = `CEIL_CYC(`T_ADDR_TO_END_NS);
  localparam [31:0] WP_FULL   = (WP_SETUP > WP_ADDR) ? WP_SETUP : WP_ADDR;
  localparam [31:0] GAP_FULL  = `CEIL_CYC(`T_FLOAT_NS);
  localparam [31:0] WAKE_FULL = `CEIL_CYC(`T_RECOVERY_NS);
  // counts are small; cut to the counter width on purpose
  localparam [`CNT_W-1:0] CYC_RD   = RD_FULL[`CNT_W-1:0];
  localparam [`CNT_W-1:0] CYC_WP   = WP_FULL[`CNT_W-1:0];
  localparam [`CNT_W-1:0] CYC_GAP  = GAP_FULL[`CNT_W-1:0];
  localparam [`CNT_W-1:0] CYC_WAKE = WAKE_FULL[`CNT_W-1:0];

  reg  [6:0]          state_ff;
  reg  [6:0]          nxt_state;
  reg                 load;
  reg  [`CNT_W-1:0]   load_cnt;
  wire                done;
  reg  [`DATA_W-1:0]  pins_meta_ff;
  reg  [`DATA_W-1:0]  pins_sync_ff;

  sram_host_delay u_delay (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_load    (load),
    .i_count   (load_cnt),
    .o_done    (done)
  );

  // ========================================================================
  // pin input synchroniser
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pins_meta_ff <= {`DATA_W{1'b0}};
      pins_sync_ff <= {`DATA_W{1'b0}};
    end else begin
      pins_meta_ff <= i_data_pins;
      pins_sync_ff <= pins_meta_ff;
    end
  end

  // ========================================================================
  // next state
  always @* begin
    nxt_state = state_ff;
    load      = 1'b0;
    load_cnt  = `CNT_ZERO;
    case (state_ff)
      ST_IDLE: begin
        if (i_retain) begin
          nxt_state = ST_RETAIN;
        end else if (i_req) begin
          load = 1'b1;
          if (i_req_write) begin
            nxt_state = ST_WR;
            load_cnt  = CYC_WP;
          end else begin
            nxt_state = ST_RD;
            load_cnt  = CYC_RD;
          end
        end
      end
      ST_RD: begin
        if (done) begin
          nxt_state = ST_GAP;
          load      = 1'b1;
          load_cnt  = CYC_GAP;
        end
      end
      ST_WR: begin
        if (done) begin
          nxt_state = ST_WR_END;
        end
      end
      ST_WR_END: begin
        nxt_state = ST_GAP;
        load      = 1'b1;
        load_cnt  = CYC_GAP;
      end
      ST_GAP: begin
        if (done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        if (!i_retain) begin
          nxt_state = ST_WAKE;
          load      = 1'b1;
          load_cnt  = CYC_WAKE;
        end
      end
      ST_WAKE: begin
        if (done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // pin and answer registers
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff       <= ST_IDLE;
      o_ready        <= 1'b0;
      o_rvalid       <= 1'b0;
      o_rdata        <= {`DATA_W{1'b0}};
      o_word_address <= {`ADDR_W{1'b0}};
      o_cs_n         <= 1'b1;
      o_oe_n         <= 1'b1;
      o_we_n         <= 1'b1;
      o_data_pins    <= {`DATA_W{1'b0}};
      o_data_pins_oe <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_rvalid <= 1'b0;
      o_ready  <= (nxt_state == ST_IDLE) && !(state_ff == ST_IDLE && i_req);
      case (nxt_state)
        ST_RD: begin
          if (state_ff == ST_IDLE) begin
            o_word_address <= i_req_addr;
          end
          o_cs_n <= 1'b0;
          o_oe_n <= 1'b0;
          o_we_n <= 1'b1;
        end
        ST_WR: begin
          // select, enable and data all start together, so the device
          // never drives during the write
          if (state_ff == ST_IDLE) begin
            o_word_address <= i_req_addr;
            o_data_pins    <= i_req_wdata;
          end
          o_cs_n         <= 1'b0;
          o_oe_n         <= 1'b1;
          o_we_n         <= 1'b0;
          o_data_pins_oe <= 1'b1;
        end
        ST_WR_END: begin
          // strobes rise first; address and data held one more cycle
          o_cs_n <= 1'b1;
          o_we_n <= 1'b1;
        end
        default: begin
          o_cs_n         <= 1'b1;
          o_oe_n         <= 1'b1;
          o_we_n         <= 1'b1;
          o_data_pins_oe <= 1'b0;
        end
      endcase
      if (state_ff == ST_RD && done) begin
        o_rdata  <= pins_sync_ff;
        o_rvalid <= 1'b1;
      end
    end
  end

endmodule // sram_host_ctrl

/* design/sram_host_map.vh */
// timing constants and field widths for the static memory host controller
`ifndef SRAM_HOST_MAP_VH
`define SRAM_HOST_MAP_VH

// ==========================================================================
// widths
`define ADDR_W              19
`define DATA_W              8

// ==========================================================================
// clock and times in ns (slow grade, the safe default)
`define CLK_PERIOD_NS       8
`define T_CYCLE_NS          70
`define T_ACCESS_NS         70
`define T_WRITE_PULSE_NS    50
`define T_ADDR_TO_END_NS    60
`define T_DATA_SETUP_NS     30
`define T_FLOAT_NS          25
`define T_RECOVERY_NS       70

// ==========================================================================
// least times round up to whole cycles
`define CEIL_CYC(t)         (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W               5
`define CNT_ZERO            5'h00
`define CNT_ONE             5'h01

`endif

/* design/sram_host_delay.v */
// down counter that raises a done flag when a loaded wait runs out
`timescale 1ns/1ps
`include "sram_host_map.vh"

module sram_host_delay (
  // clock and reset
  input  wire                i_clk_sys,
  input  wire                i_arst_n,
  // control
  input  wire                i_load,
  input  wire [`CNT_W-1:0]   i_count,
  // status
  output reg                 o_done
);

  reg [`CNT_W-1:0] cnt_ff;

  // ========================================================================
  // countdown
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= `CNT_ZERO;
      o_done <= 1'b1;
    end else if (i_load) begin
      cnt_ff <= i_count;
      o_done <= (i_count == `CNT_ZERO);
    end else if (cnt_ff != `CNT_ZERO) begin
      cnt_ff <= cnt_ff - `CNT_ONE;
      o_done <= (cnt_ff == `CNT_ONE);
    end
  end

endmodule // sram_host_delay

/* tb/sram_host_ctrl_asserts.sv */
// pin timing checks for the static memory host controller
`timescale 1ns/1ps
`include "sram_host_map.vh"
module sram_host_ctrl_chk (
  // clock and reset
  input wire               i_clk_sys,
  input wire               i_arst_n,
  // watched ports
  input wire               i_retain,
  input wire [`ADDR_W-1:0] o_word_address,
  input wire               o_cs_n,
  input wire               o_oe_n,
  input wire               o_we_n,
  input wire [`DATA_W-1:0] o_data_pins,
  input wire               o_data_pins_oe
);
  // ==========================================================================
  // properties, one clock cycle is 8 ns
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  property p_cycle; $fell(o_cs_n) |=> $stable(o_word_address) [*8]; endproperty
  a_cycle: assert property (p_cycle) else $error("cycle too short");
  // 50 ns of write pulse needs seven whole periods, so eight low samples
  property p_pulse; $fell(o_we_n) |-> !o_we_n [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("write short");
  property p_addr; !$past(o_we_n) |-> $stable(o_word_address); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_sel; $fell(o_we_n) |-> !o_cs_n [*8]; endproperty
  a_sel: assert property (p_sel) else $error("select short");
  property p_data;
    !$past(o_we_n) |-> o_data_pins_oe && $stable(o_data_pins);
  endproperty
  a_data: assert property (p_data) else $error("data moved");
  // 25 ns float needs four cycles of output enable high
  property p_turn; o_data_pins_oe |-> o_oe_n && $past(o_oe_n, 4); endproperty
  a_turn: assert property (p_turn) else $error("bus clash");
  property p_wroe; !o_we_n |-> o_oe_n; endproperty
  a_wroe: assert property (p_wroe) else $error("write with oe low");
  // a 70 ns read cycle is nine 8 ns cycles of wait after retention drops
  reg [3:0] wake_left_ff;
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wake_left_ff <= 4'h0;
    end else if (i_retain) begin
      wake_left_ff <= 4'h9;
    end else if (wake_left_ff != 4'h0) begin
      wake_left_ff <= wake_left_ff - 4'h1;
    end
  end
  property p_wake; (wake_left_ff != 4'h0) && !i_retain |-> o_cs_n; endproperty
  a_wake: assert property (p_wake) else $error("early wake");
endmodule // sram_host_ctrl_chk

bind sram_host_ctrl sram_host_ctrl_chk u_chk (
  .i_clk_sys      (i_clk_sys),
  .i_arst_n       (i_arst_n),
  .i_retain       (i_retain),
  .o_word_address (o_word_address),
  .o_cs_n         (o_cs_n),
  .o_oe_n         (o_oe_n),
  .o_we_n         (o_we_n),
  .o_data_pins    (o_data_pins),
  .o_data_pins_oe (o_data_pins_oe)
);

/* tb/sram_dev_model.sv */
// behavioural 512K x 8 static memory, slow grade timing
`timescale 1ns/1ps
module sram_dev_model (
  // pins
  input  wire [18:0] i_addr,
  input  wire        i_cs_n,
  input  wire        i_oe_n,
  input  wire        i_we_n,
  input  wire [7:0]  i_dq,
  output reg  [7:0]  o_dq
);
  // ==========================================================================
  // storage, no clock and no reset
  reg  [7:0] mem [0:524287];
  wire       rd = !i_cs_n && !i_oe_n && i_we_n;
  wire       wr = !i_cs_n && !i_we_n;
  initial o_dq = 8'ha5;
  // junk until the access time runs out, so early sampling is caught
  always @(rd or i_addr) begin
    o_dq <= #10 ~o_dq;
    if (rd) o_dq <= #70 mem[i_addr];
  end
  always @(negedge wr) mem[i_addr] = i_dq;
endmodule // sram_dev_model

/* tb/testbench.sv */
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
`include "sram_host_map.vh"
module testbench;
  // ==========================================================================
  // signals
  reg                i_clk_sys = 1'b0;
  reg                i_arst_n = 1'b0;
  reg                i_req = 1'b0;
  reg                i_req_write = 1'b0;
  reg [`ADDR_W-1:0]  i_req_addr = 19'h00000;
  reg [`DATA_W-1:0]  i_req_wdata = 8'h00;
  reg                i_retain = 1'b0;
  wire               o_ready, o_rvalid, o_cs_n, o_oe_n, o_we_n, o_data_pins_oe;
  wire [`DATA_W-1:0] o_rdata, o_data_pins, dev_dq;
  wire [`ADDR_W-1:0] o_word_address;
  wire [`DATA_W-1:0] i_data_pins = o_data_pins_oe ? o_data_pins : dev_dq;
  integer            err_total = 0;
  integer            comparisons = 0;
  integer            i;
  reg [7:0]          q;
  reg [27:0]         rows [0:7];
  always #4 i_clk_sys = ~i_clk_sys;
  sram_host_ctrl DUT (
    .i_clk_sys      (i_clk_sys),
    .i_arst_n       (i_arst_n),
    .i_req          (i_req),
    .i_req_write    (i_req_write),
    .i_req_addr     (i_req_addr),
    .i_req_wdata    (i_req_wdata),
    .i_retain       (i_retain),
    .o_ready        (o_ready),
    .o_rvalid       (o_rvalid),
    .o_rdata        (o_rdata),
    .o_word_address (o_word_address),
    .o_cs_n         (o_cs_n),
    .o_oe_n         (o_oe_n),
    .o_we_n         (o_we_n),
    .i_data_pins    (i_data_pins),
    .o_data_pins    (o_data_pins),
    .o_data_pins_oe (o_data_pins_oe)
  );
  sram_dev_model u_mem (.i_addr(o_word_address), .i_cs_n(o_cs_n),
    .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_dq(i_data_pins), .o_dq(dev_dq));
  // ==========================================================================
  // tasks
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task results;
    begin
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // request held until an edge sees ready; reads wait for the pulse
  task op(input w, input [18:0] a, input [7:0] d, output [7:0] rq);
    integer n;
    begin
      @(posedge i_clk_sys);
      i_req <= 1'b1;
      i_req_write <= w;
      i_req_addr <= a;
      i_req_wdata <= d;
      n = 0;
      do begin @(posedge i_clk_sys); n = n + 1; end
      while (o_ready !== 1'b1 && n < 50);
      i_req <= 1'b0;
      if (n >= 50) err_total = err_total + 1;
      n = 0;
      while (!w && o_rvalid !== 1'b1 && n < 50) begin
        @(posedge i_clk_sys);
        n = n + 1;
      end
      if (n >= 50) err_total = err_total + 1;
      rq = o_rdata;
    end
  endtask
  // ==========================================================================
  // sequence
  initial begin
    rows[0] = {1'b1, 19'h00000, 8'h3c};
    rows[1] = {1'b1, 19'h7ffff, 8'hc3};
    rows[2] = {1'b1, 19'h2a5a5, 8'h5a};
    rows[3] = {1'b0, 19'h00000, 8'h3c};
    rows[4] = {1'b0, 19'h7ffff, 8'hc3};
    rows[5] = {1'b1, 19'h2a5a5, 8'ha5};
    rows[6] = {1'b0, 19'h2a5a5, 8'ha5};
    rows[7] = {1'b0, 19'h7ffff, 8'hc3};
    repeat (6) @(posedge i_clk_sys);
    check("select in reset", o_cs_n, 1'b1);
    check("drive in reset", o_data_pins_oe, 1'b0);
    i_arst_n <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      op(rows[i][27], rows[i][26:8], rows[i][7:0], q);
      if (!rows[i][27]) check("read byte", q, rows[i][7:0]);
    end
    // request while busy must be dropped
    op(1'b1, 19'h00100, 8'h11, q);
    @(posedge i_clk_sys);
    i_req <= 1'b1;
    i_req_wdata <= 8'hee;
    repeat (4) @(posedge i_clk_sys);
    check("ready while busy", o_ready, 1'b0);
    i_req <= 1'b0;
    op(1'b0, 19'h00100, 8'h00, q);
    check("busy write ignored", q, 8'h11);
    // retention holds off a pending write
    i_retain <= 1'b1;
    i_req <= 1'b1;
    i_req_write <= 1'b1;
    i_req_wdata <= 8'hee;
    repeat (20) @(posedge i_clk_sys);
    check("select in retention", o_cs_n, 1'b1);
    check("ready in retention", o_ready, 1'b0);
    i_retain <= 1'b0;
    i_req <= 1'b0;
    op(1'b0, 19'h00100, 8'h00, q);
    check("byte after retention", q, 8'h11);
    results;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    results;
  end
endmodule // testbench
